// ===== shared/msahf_consts.svh
// offsets, reset values and field positions for the station address and hash filter block
`ifndef MSAHF_CONSTS_SVH
`define MSAHF_CONSTS_SVH

`define MSAHF_ADDR_W          8
`define MSAHF_OFS_ADDR_HIGH   8'h02
`define MSAHF_OFS_ADDR_LOW    8'h03
`define MSAHF_OFS_HASH_UPPER  8'h04
`define MSAHF_OFS_HASH_LOWER  8'h05
`define MSAHF_OFS_FILT_CTRL   8'h10
`define MSAHF_OFS_FILT_STAT   8'h11

`define MSAHF_RST_ADDR_HIGH   32'h0000ffff
`define MSAHF_RST_ADDR_LOW    32'h0fffffff
`define MSAHF_RST_HASH        32'h00000000

`define MSAHF_CFG_FIRST_LOC   8'h01
`define MSAHF_CFG_LAST_LOC    8'h06
`define MSAHF_CFG_SIG_LOC     8'h00
`define MSAHF_CFG_SIG_VALUE   8'ha5

`define MSAHF_CTRL_PASS_ALL   0
`define MSAHF_STAT_LOADED     0
`define MSAHF_STAT_DONE       1

`define MSAHF_CRC_INIT        32'hffffffff
`define MSAHF_CRC_POLY        32'hedb88320

`endif

// ===== shared/msahf_pkg.sv
// types shared by the station address and hash filter block
package msahf_pkg;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } msahf_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       first;
    } msahf_rx_byte_t;

    typedef struct packed {
        logic valid;
        logic unicast_hit;
        logic group_frame;
        logic group_accept;
    } msahf_verdict_t;

    typedef enum logic [2:0] {
        msahf_st_sig_req,
        msahf_st_sig_wait,
        msahf_st_byte_req,
        msahf_st_byte_wait,
        msahf_st_done
    } msahf_load_state_t;
endpackage

// ===== src/msahf_hash_crc.sv
// crc-32 over the six destination bytes, giving the six-bit group hash index
`timescale 1ns/10ps
`include "msahf_consts.svh"
module msahf_hash_crc (
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic       start,
    input  wire logic       byte_valid,
    input  wire logic [7:0] byte_data,
    output logic      [5:0] hash_index
);
    import msahf_pkg::*;

    logic [31:0] crc;
    logic [31:0] next_crc;
    logic [31:0] crc_base;
    logic [31:0] crc_final;

    assign crc_base = start ? `MSAHF_CRC_INIT : crc;

    always_comb begin
        next_crc = crc_base;
        for (int b = 0; b < 8; b++) begin
            if (next_crc[0] ^ byte_data[b]) begin
                next_crc = (next_crc >> 1) ^ `MSAHF_CRC_POLY;
            end else begin
                next_crc = next_crc >> 1;
            end
        end
    end

    // standard crc value is the complemented register, bit 31 on top
    generate
        for (genvar i = 0; i < 32; i++) begin : g_fin
            assign crc_final[i] = ~next_crc[i];
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            crc        <= `MSAHF_CRC_INIT;
            hash_index <= 6'h00;
        end else if (byte_valid) begin
            crc        <= next_crc;
            hash_index <= crc_final[31:26];
        end
    end
endmodule

// ===== src/msahf_top.sv
// station address and group hash filter with power-on load from configuration memory
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
`include "msahf_consts.svh"
module msahf_top (
    input  wire logic                     ref_clk,
    input  wire logic                     srst,
    input  wire msahf_pkg::msahf_req_t    bus_req,
    output logic                   [31:0] bus_rdata,
    output logic                          cfg_rd_req,
    output logic                    [7:0] cfg_rd_loc,
    input  wire logic                     cfg_rd_valid,
    input  wire logic               [7:0] cfg_rd_data,
    input  wire logic                     cfg_present,
    input  wire msahf_pkg::msahf_rx_byte_t rx_byte,
    input  wire logic                     rx_frame_end,
    output msahf_pkg::msahf_verdict_t     verdict,
    output logic                          load_done
);
    import msahf_pkg::*;

    logic [31:0]       station_address_high;
    logic [31:0]       station_address_low;
    logic [31:0]       group_hash_upper;
    logic [31:0]       group_hash_lower;
    logic              pass_all_group_frames;
    logic              addr_loaded;
    msahf_load_state_t state;
    msahf_load_state_t next_state;
    logic [7:0]        next_loc;
    logic [2:0]        rx_count;
    logic              match_run;
    logic              group_bit;
    logic              frame_seen;
    logic              cfg_present_s1;
    logic              cfg_present_s2;
    logic [5:0]        hash_index;

    // address decode
    wire sel_high  = bus_req.addr == `MSAHF_OFS_ADDR_HIGH;
    wire sel_low   = bus_req.addr == `MSAHF_OFS_ADDR_LOW;
    wire sel_hup   = bus_req.addr == `MSAHF_OFS_HASH_UPPER;
    wire sel_hlo   = bus_req.addr == `MSAHF_OFS_HASH_LOWER;
    wire sel_ctrl  = bus_req.addr == `MSAHF_OFS_FILT_CTRL;
    wire sel_stat  = bus_req.addr == `MSAHF_OFS_FILT_STAT;
    wire host_ok   = state == msahf_st_done;
    wire wr_high   = bus_req.wr && sel_high && host_ok;
    wire wr_low    = bus_req.wr && sel_low && host_ok;

    logic [31:0] rd_mux;
    always_comb begin
        if (sel_high) begin
            rd_mux = {16'h0000, station_address_high[15:0]};
        end else if (sel_low) begin
            rd_mux = station_address_low;
        end else if (sel_hup) begin
            rd_mux = group_hash_upper;
        end else if (sel_hlo) begin
            rd_mux = group_hash_lower;
        end else if (sel_ctrl) begin
            rd_mux = {31'h00000000, pass_all_group_frames};
        end else if (sel_stat) begin
            rd_mux = {30'h00000000, load_done, addr_loaded};
        end else begin
            rd_mux = 32'h00000000;
        end
    end

    // presence pin is asynchronous; kept out of reset so both stages
    // already hold the pin level when the loader first looks at it
    always_ff @(posedge ref_clk) begin
        cfg_present_s1 <= cfg_present;
        cfg_present_s2 <= cfg_present_s1;
    end

    // power-on loader: signature check, then bytes 0x01..0x06
    wire sig_ok   = cfg_rd_data == `MSAHF_CFG_SIG_VALUE;
    wire last_loc = cfg_rd_loc == `MSAHF_CFG_LAST_LOC;

    always_comb begin
        next_state = state;
        next_loc   = cfg_rd_loc;
        case (state)
            msahf_st_sig_req: begin
                if (cfg_present_s2) begin
                    next_state = msahf_st_sig_wait;
                    next_loc   = `MSAHF_CFG_SIG_LOC;
                end else begin
                    next_state = msahf_st_done;
                end
            end
            msahf_st_sig_wait: begin
                if (cfg_rd_valid) begin
                    next_state = sig_ok ? msahf_st_byte_req : msahf_st_done;
                    next_loc   = `MSAHF_CFG_FIRST_LOC;
                end
            end
            msahf_st_byte_req: begin
                next_state = msahf_st_byte_wait;
            end
            msahf_st_byte_wait: begin
                if (cfg_rd_valid) begin
                    if (last_loc) begin
                        next_state = msahf_st_done;
                    end else begin
                        next_state = msahf_st_byte_req;
                        next_loc   = cfg_rd_loc + 8'h01;
                    end
                end
            end
            default: begin
                next_state = msahf_st_done;
            end
        endcase
    end

    wire load_byte = state == msahf_st_byte_wait && cfg_rd_valid;
    wire start_req = (state == msahf_st_sig_req && cfg_present_s2) || state == msahf_st_byte_req;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state      <= msahf_st_sig_req;
            cfg_rd_loc <= 8'h00;
            cfg_rd_req <= 1'b0;
            load_done  <= 1'b0;
        end else begin
            state      <= next_state;
            cfg_rd_loc <= next_loc;
            cfg_rd_req <= start_req;
            load_done  <= next_state == msahf_st_done;
        end
    end

    // address registers: reset default, loader bytes, then host writes
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            station_address_high <= `MSAHF_RST_ADDR_HIGH;
            station_address_low  <= `MSAHF_RST_ADDR_LOW;
            addr_loaded          <= 1'b0;
        end else if (load_byte) begin
            case (cfg_rd_loc)
                8'h01: station_address_low[7:0]   <= cfg_rd_data;
                8'h02: station_address_low[15:8]  <= cfg_rd_data;
                8'h03: station_address_low[23:16] <= cfg_rd_data;
                8'h04: station_address_low[31:24] <= cfg_rd_data;
                8'h05: station_address_high[7:0]  <= cfg_rd_data;
                default: station_address_high[15:8] <= cfg_rd_data;
            endcase
            addr_loaded <= last_loc;
        end else begin
            if (wr_high) begin
                station_address_high <= {16'h0000, bus_req.wdata[15:0]};
            end
            if (wr_low) begin
                station_address_low <= bus_req.wdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            group_hash_upper      <= `MSAHF_RST_HASH;
            group_hash_lower      <= `MSAHF_RST_HASH;
            pass_all_group_frames <= 1'b0;
            bus_rdata             <= 32'h00000000;
        end else begin
            if (bus_req.wr && sel_hup) begin
                group_hash_upper <= bus_req.wdata;
            end
            if (bus_req.wr && sel_hlo) begin
                group_hash_lower <= bus_req.wdata;
            end
            if (bus_req.wr && sel_ctrl) begin
                pass_all_group_frames <= bus_req.wdata[`MSAHF_CTRL_PASS_ALL];
            end
            bus_rdata <= bus_req.rd ? rd_mux : 32'h00000000;
        end
    end

    // destination match: byte n of the frame against register byte n
    wire [47:0] station = {station_address_high[15:0], station_address_low};
    wire [2:0]  pos     = rx_byte.first ? 3'h0 : rx_count;
    wire [7:0]  expect_byte = station[{pos, 3'b000} +: 8];
    wire        in_dest = rx_byte.valid && (rx_byte.first || (frame_seen && rx_count < 3'h6));
    wire        byte_eq = rx_byte.data == expect_byte;

    msahf_hash_crc u_hash (
        .ref_clk    (ref_clk),
        .srst       (srst),
        .start      (rx_byte.first),
        .byte_valid (in_dest),
        .byte_data  (rx_byte.data),
        .hash_index (hash_index)
    );

    // top index bit picks the register, low five the bit
    wire [31:0] hash_word = hash_index[5] ? group_hash_upper : group_hash_lower;
    wire        table_hit = hash_word[hash_index[4:0]];

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rx_count   <= 3'h0;
            match_run  <= 1'b0;
            group_bit  <= 1'b0;
            frame_seen <= 1'b0;
            verdict    <= '0;
        end else begin
            verdict.valid <= 1'b0;
            if (in_dest) begin
                rx_count   <= pos + 3'h1;
                frame_seen <= 1'b1;
                match_run  <= (rx_byte.first || match_run) && byte_eq;
                if (rx_byte.first) begin
                    group_bit <= rx_byte.data[0];
                end
            end
            if (rx_frame_end && frame_seen) begin
                frame_seen           <= 1'b0;
                rx_count             <= 3'h0;
                verdict.valid        <= 1'b1;
                verdict.unicast_hit  <= match_run && rx_count == 3'h6;
                verdict.group_frame  <= group_bit;
                verdict.group_accept <= group_bit && (pass_all_group_frames || table_hit);
            end
        end
    end
endmodule

// ===== test/msahf_top_monitor.sv
// concurrent checks on the ports of the station address and hash filter block
`timescale 1ns/10ps
`include "msahf_consts.svh"
module msahf_top_monitor (
    input wire logic                      ref_clk,
    input wire logic                      srst,
    input wire msahf_pkg::msahf_req_t     bus_req,
    input wire logic               [31:0] bus_rdata,
    input wire logic                      cfg_rd_req,
    input wire logic                [7:0] cfg_rd_loc,
    input wire logic                      cfg_rd_valid,
    input wire logic                      rx_frame_end,
    input wire msahf_pkg::msahf_verdict_t verdict,
    input wire logic                      load_done
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence s_rd_high;
        bus_req.rd && bus_req.addr == `MSAHF_OFS_ADDR_HIGH;
    endsequence
    sequence s_rd_unmapped;
        bus_req.rd && bus_req.addr == 8'h07;
    endsequence
    a_rdata_idle_zero: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
        else $error("read data not zero outside read answer");
    a_high_top_reserved: assert property (s_rd_high |=> bus_rdata[31:16] == 16'h0)
        else $error("high address top half not zero");
    a_unmapped_reads_zero: assert property (s_rd_unmapped |=> bus_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_cfg_req_pulse: assert property (cfg_rd_req |=> !cfg_rd_req)
        else $error("config request longer than one cycle");
    a_cfg_loc_held: assert property (cfg_rd_req |=> $stable(cfg_rd_loc))
        else $error("config location moved while waiting");
    a_cfg_loc_range: assert property (cfg_rd_req |-> cfg_rd_loc <= 8'h06)
        else $error("config location out of range");
    a_load_done_holds: assert property (load_done |=> load_done && !cfg_rd_req)
        else $error("load done dropped or loader restarted");
    a_verdict_pulse: assert property (verdict.valid |=> !verdict.valid)
        else $error("verdict valid longer than one cycle");
    a_verdict_after_end: assert property (verdict.valid |-> $past(rx_frame_end))
        else $error("verdict without frame end");
endmodule
bind msahf_top msahf_top_monitor MON (.ref_clk, .srst, .bus_req, .bus_rdata, .cfg_rd_req, .cfg_rd_loc,
    .cfg_rd_valid, .rx_frame_end, .verdict, .load_done);

// ===== test/msahf_cfg_model.sv
// configuration memory model answering byte reads with varying latency
`timescale 1ns/10ps
module msahf_cfg_model (
    input  wire logic       ref_clk,
    input  wire logic       cfg_rd_req,
    input  wire logic [7:0] cfg_rd_loc,
    output logic            cfg_rd_valid,
    output logic      [7:0] cfg_rd_data
);
    logic [7:0] mem [0:7];
    logic [7:0] loc;
    int         cnt;
    initial begin
        mem = '{8'ha5, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc, 8'h00};
        cnt = 0;
        loc = 8'h0;
        cfg_rd_valid = 1'b0;
        cfg_rd_data = 8'h5a;
    end
    // data toggles when not answering; odd locations answer fast, even slow
    always @(posedge ref_clk) begin
        cfg_rd_valid <= 1'b0;
        cfg_rd_data <= ~cfg_rd_data;
        if (cfg_rd_req) begin
            loc <= cfg_rd_loc;
            cnt <= cfg_rd_loc[0] ? 1 : 4;
        end else if (cnt == 1) begin
            cfg_rd_valid <= 1'b1;
            cfg_rd_data <= mem[loc[2:0]];
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// ===== test/tb_top.sv
// self-checking bench for the station address and hash filter block
`timescale 1ns/10ps
`include "msahf_consts.svh"
module tb_top;
    import msahf_pkg::*;
    logic           ref_clk, srst, cfg_present, cfg_rd_req, cfg_rd_valid, rx_frame_end, load_done;
    logic [7:0]     cfg_rd_loc, cfg_rd_data;
    logic [31:0]    bus_rdata;
    msahf_req_t     bus_req;
    msahf_rx_byte_t rx_byte;
    msahf_verdict_t verdict;
    int             fails, num_checks;

    msahf_top DUT (.ref_clk(ref_clk), .srst(srst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .cfg_rd_req(cfg_rd_req), .cfg_rd_loc(cfg_rd_loc), .cfg_rd_valid(cfg_rd_valid),
        .cfg_rd_data(cfg_rd_data), .cfg_present(cfg_present), .rx_byte(rx_byte),
        .rx_frame_end(rx_frame_end), .verdict(verdict), .load_done(load_done));
    msahf_cfg_model PART (.ref_clk(ref_clk), .cfg_rd_req(cfg_rd_req), .cfg_rd_loc(cfg_rd_loc),
        .cfg_rd_valid(cfg_rd_valid), .cfg_rd_data(cfg_rd_data));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic results();
        if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1 chk(bus_rdata, exp);
    endtask

    task automatic do_reset(input logic present);
        int i;
        cfg_present <= present;
        srst <= 1'b1;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        for (i = 0; i < 200 && load_done !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        chk({31'h0, load_done}, 32'h1);
    endtask

    // d[47:40] goes out first; expect {unicast, group, accept}
    task automatic frame(input logic [47:0] d, input logic [2:0] exp);
        int i;
        for (i = 0; i < 6; i++) begin
            @(posedge ref_clk);
            rx_byte <= '{valid: 1'b1, data: d[47-8*i -: 8], first: i == 0};
        end
        @(posedge ref_clk);
        rx_byte <= '0;
        @(posedge ref_clk);
        rx_frame_end <= 1'b1;
        @(posedge ref_clk);
        rx_frame_end <= 1'b0;
        #1;
        for (i = 0; i < 4 && verdict.valid !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        chk({28'h0, verdict.valid, verdict.unicast_hit, verdict.group_frame, verdict.group_accept},
            {28'h0, 1'b1, exp});
    endtask

    function automatic logic [5:0] hash_of(input logic [47:0] d);
        logic [31:0] c;
        c = `MSAHF_CRC_INIT;
        for (int i = 0; i < 6; i++)
            for (int b = 0; b < 8; b++)
                c = (c[0] ^ d[40-8*i+b]) ? (c >> 1) ^ `MSAHF_CRC_POLY : c >> 1;
        c = ~c;
        return c[31:26];
    endfunction

    task automatic t_loaded();
        rd(`MSAHF_OFS_ADDR_LOW, 32'h78563412);
        rd(`MSAHF_OFS_ADDR_HIGH, 32'h0000bc9a);
        rd(`MSAHF_OFS_FILT_STAT, 32'h3);
    endtask

    task automatic t_regs();
        wr(`MSAHF_OFS_ADDR_HIGH, 32'hffffffff);
        rd(`MSAHF_OFS_ADDR_HIGH, 32'h0000ffff);
        wr(`MSAHF_OFS_ADDR_LOW, 32'ha1b2c3d4);
        rd(`MSAHF_OFS_ADDR_LOW, 32'ha1b2c3d4);
        wr(`MSAHF_OFS_HASH_UPPER, 32'hdeadbeef);
        wr(`MSAHF_OFS_HASH_LOWER, 32'h01234567);
        rd(`MSAHF_OFS_HASH_UPPER, 32'hdeadbeef);
        rd(`MSAHF_OFS_HASH_LOWER, 32'h01234567);
        wr(8'h07, 32'hffffffff);
        rd(8'h07, 32'h0);
        wr(`MSAHF_OFS_ADDR_LOW, 32'h78563412);
        wr(`MSAHF_OFS_ADDR_HIGH, 32'h0000bc9a);
    endtask

    task automatic t_unicast();
        frame(48'h123456789abc, 3'b100);
        frame(48'hbc9a78563412, 3'b000);
    endtask

    task automatic t_group(input logic [47:0] d);
        logic [63:0] m;
        m = 64'h1 << hash_of(d);
        wr(`MSAHF_OFS_HASH_UPPER, m[63:32]);
        wr(`MSAHF_OFS_HASH_LOWER, m[31:0]);
        frame(d, 3'b011);
        wr(`MSAHF_OFS_HASH_UPPER, ~m[63:32]);
        wr(`MSAHF_OFS_HASH_LOWER, ~m[31:0]);
        frame(d, 3'b010);
        wr(`MSAHF_OFS_FILT_CTRL, 32'h1);
        frame(d, 3'b011);
        wr(`MSAHF_OFS_FILT_CTRL, 32'h0);
    endtask

    task automatic t_skip();
        do_reset(1'b0);
        rd(`MSAHF_OFS_ADDR_LOW, `MSAHF_RST_ADDR_LOW);
        rd(`MSAHF_OFS_ADDR_HIGH, `MSAHF_RST_ADDR_HIGH);
        rd(`MSAHF_OFS_FILT_STAT, 32'h2);
    endtask

    initial begin
        #200000;
        fails++;
        results();
    end

    initial begin
        srst = 1'b1;
        cfg_present = 1'b1;
        bus_req = '0;
        rx_byte = '0;
        rx_frame_end = 1'b0;
        fails = 0;
        num_checks = 0;
        do_reset(1'b1);
        t_loaded();
        t_regs();
        t_unicast();
        t_group(48'h01005e000001);
        t_group(48'h333300000001);
        t_skip();
        results();
    end
endmodule
